// ---- scf_deser_model.sv ----
// scf_deser_model.sv: far-end receiver model of the serial pair.
// assumes: one bit per clk_i, lsb first; undriven pair is ignored.
`timescale 1ns/100ps
`default_nettype none
module scf_deser_model (
  input wire logic clk_i,
  input wire logic serial_p_i,
  input wire logic serial_n_i,
  input wire logic serial_oe_i,
  output logic [9:0] rx_word_o,
  output logic line_err_o
);
  // ========
  // receiver: newest bit enters at the top
  initial begin
    rx_word_o = 10'h000;
    line_err_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (serial_oe_i) begin
      rx_word_o <= {serial_p_i, rx_word_o[9:1]};
      // a driven pair must be complementary
      if (serial_p_i === serial_n_i) begin
        line_err_o <= 1'b1;
      end
    end
  end
endmodule : scf_deser_model
`default_nettype wire

// ---- scf_front_end.sv ----
// scf_front_end.sv: control and data-input front end of a 10:1 serializer,
// with a classic wishbone register slave.
// assumes: all pins synchronous to clk_i (40 MHz); transmit clock arrives as a
// plain sampled input well below half the clk_i rate; rst_i is synchronous.
//
// Functional notes
// RQ1: output enable low tristates both outputs
// RQ2: output enable high drives serial data
// RQ3: accept ten-bit parallel input word
// RQ4: latch word on selected clock edge
// RQ5: transmit clock is the pll reference
// RQ6: source supplies 10 to 66 MHz clock
// RQ7: edge select low latches on falling
// RQ8: edge select high latches on rising
// RQ9: power-down low stops pll, low power
// RQ10: power-down low tristates the outputs
// RQ11: two sync requests combined by or
// RQ12: request high six cycles starts burst
// RQ13: a burst sends at least 1026 patterns
// RQ14: held request extends burst until released
// RQ15: fresh request starts another full burst
// RQ16: transmit only when enabled and awake
// RQ17: 1026 clock initialisation after power-down
// RQ18: enable high again resumes previous state
// RQ19: fixed sync word replaces input data
// RQ20: count request time and sent patterns
`timescale 1ns/100ps
`default_nettype none
`include "scf_regs.svh"

module scf_front_end #(
  parameter int DATA_W = 10, // parallel word width
  parameter int CNT_W = 11, // pattern and init counter width
  parameter int SYNC_HOLD = `SCF_SYNC_HOLD, // request hold time
  parameter int BURST_LEN = `SCF_BURST_LEN, // least patterns per burst
  parameter int INIT_LEN = `SCF_INIT_LEN // initialisation cycles
) (
  input wire logic clk_i, // system clock, 40 MHz
  input wire logic rst_i, // synchronous reset, active high
  // wishbone slave
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  // parallel source side
  input wire logic transmit_clock_i, // transmit clock, sampled
  input wire logic transmit_strobe_edge_select_i, // high rising, low falling
  input wire logic [DATA_W-1:0] parallel_data_in_i, // parallel word
  input wire logic serial_output_enable_i, // serial output enable
  input wire logic power_down_n_i, // power-down, active low
  input wire logic sync_request_a_i, // sync request a
  input wire logic sync_request_b_i, // sync request b
  // serial line and pll side
  output logic serial_p_o, // noninverting serial output
  output logic serial_n_o, // inverting serial output
  output logic serial_oe_o, // drive enable of the pair
  output logic pll_ref_o, // reference clock towards the pll
  output logic pll_en_o, // pll running
  output logic low_power_o // low-power state
);

  // ============================================================
  // elaboration checks
  if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
    $error("scf_front_end: DATA_W must lie in 2..32");
  end
  if (BURST_LEN >= (1 << CNT_W) || INIT_LEN >= (1 << CNT_W) || CNT_W < 11) begin : g_bad_cnt
    $error("scf_front_end: CNT_W too narrow for the counts");
  end
  if (SYNC_HOLD < 1 || SYNC_HOLD > 7) begin : g_bad_hold
    $error("scf_front_end: SYNC_HOLD must lie in 1..7");
  end

  localparam logic [CNT_W-1:0] BURST_LAST = CNT_W'(BURST_LEN); // burst minimum
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_LEN - 1); // last init cycle
  localparam logic [2:0] HOLD_LAST = 3'(SYNC_HOLD - 1); // last hold cycle
  localparam logic [DATA_W-1:0] SYNC_WORD = DATA_W'(`SCF_SYNC_WORD); // sync word

  // ============================================================
  // transmit clock sampling and edge selection
  logic transmit_clock_q_r; // previous sample of transmit clock
  logic transmit_clock_q_nxt;
  logic [DATA_W-1:0] latch_r; // input latch
  logic [DATA_W-1:0] latch_nxt;
  scf_pkg::scf_edges_t edge_s; // edges this cycle

  // edge detection and input latch next values
  always_comb begin
    transmit_clock_q_nxt = transmit_clock_i;
    edge_s.rise = transmit_clock_i & ~transmit_clock_q_r;
    edge_s.fall = ~transmit_clock_i & transmit_clock_q_r;
    // choose the latching edge
    edge_s.strobe = transmit_strobe_edge_select_i ? edge_s.rise : edge_s.fall; // RQ7 RQ8
    latch_nxt = latch_r;
    if (edge_s.strobe && power_down_n_i) begin
      latch_nxt = parallel_data_in_i; // RQ3 RQ4
    end
  end

  // register the sample and the latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_clock_q_r <= 1'b0;
      latch_r <= '0;
    end else begin
      transmit_clock_q_r <= transmit_clock_q_nxt;
      latch_r <= latch_nxt;
    end
  end

  // ============================================================
  // sequencer: initialisation, data and sync bursts
  scf_pkg::scf_state_t state_r; // sequencer state
  scf_pkg::scf_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r; // init cycles or patterns sent
  logic [CNT_W-1:0] cnt_nxt;
  logic [2:0] hold_r; // request high time in transmit clock cycles
  logic [2:0] hold_nxt;
  logic req_s; // combined sync request

  assign req_s = sync_request_a_i | sync_request_b_i; // RQ11

  // next state, counters
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    hold_nxt = hold_r;
    if (!power_down_n_i) begin
      // power-down acts as reset of the sequence
      state_nxt = scf_pkg::SCF_ST_INIT; // RQ17
      cnt_nxt = '0;
      hold_nxt = '0;
    end else begin
      case (state_r)
        scf_pkg::SCF_ST_INIT: begin
          // count transmit clocks while the pll settles
          if (edge_s.rise) begin
            if (cnt_r == INIT_LAST) begin
              state_nxt = scf_pkg::SCF_ST_DATA; // RQ17
              cnt_nxt = '0;
            end else begin
              cnt_nxt = cnt_r + 1'b1;
            end
          end
        end
        scf_pkg::SCF_ST_DATA: begin
          // measure how long the request has been high
          if (!req_s) begin
            hold_nxt = '0;
          end else if (edge_s.rise) begin
            if (hold_r == HOLD_LAST) begin
              state_nxt = scf_pkg::SCF_ST_SYNC; // RQ12 RQ15
              cnt_nxt = '0;
              hold_nxt = '0;
            end else begin
              hold_nxt = hold_r + 1'b1; // RQ20
            end
          end
        end
        scf_pkg::SCF_ST_SYNC: begin
          // one pattern per latched word, saturating at the minimum
          if (edge_s.strobe && cnt_r != BURST_LAST) begin
            cnt_nxt = cnt_r + 1'b1; // RQ20
          end
          // leave only after the minimum and with the request released
          if (cnt_r == BURST_LAST && !req_s) begin
            state_nxt = scf_pkg::SCF_ST_DATA; // RQ13 RQ14
            hold_nxt = '0;
          end
        end
        default: begin
          state_nxt = scf_pkg::SCF_ST_INIT;
          cnt_nxt = '0;
          hold_nxt = '0;
        end
      endcase
    end
  end

  // register the sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= scf_pkg::SCF_ST_INIT;
      cnt_r <= '0;
      hold_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ============================================================
  // serializer and output pins
  logic [DATA_W-1:0] shift_r; // outgoing bits, lsb first
  logic [DATA_W-1:0] shift_nxt;
  scf_pkg::scf_pair_t pair_r; // registered differential pair
  scf_pkg::scf_pair_t pair_nxt;
  logic pll_ref_r; // pll reference
  logic pll_ref_nxt;
  logic pll_en_r; // pll run
  logic pll_en_nxt;
  logic low_power_r; // low-power indication
  logic low_power_nxt;
  logic mute_r; // software mute from the control register

  // shifting, output drive and pll control
  always_comb begin
    shift_nxt = {1'b0, shift_r[DATA_W-1:1]};
    if (edge_s.strobe) begin
      // sync word replaces the data during a burst
      shift_nxt = (state_r == scf_pkg::SCF_ST_SYNC) ? SYNC_WORD : parallel_data_in_i; // RQ19
    end
    pair_nxt.p = shift_r[0];
    pair_nxt.n = ~shift_r[0];
    // enable gates drive only; state is kept while disabled
    pair_nxt.oe = serial_output_enable_i & power_down_n_i & ~mute_r
                  & (state_r != scf_pkg::SCF_ST_INIT); // RQ1 RQ2 RQ10 RQ16 RQ18
    pll_ref_nxt = transmit_clock_i & power_down_n_i; // RQ5
    pll_en_nxt = power_down_n_i; // RQ9
    low_power_nxt = ~power_down_n_i; // RQ9
  end

  // register the outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_r <= '0;
      pair_r <= '0;
      pll_ref_r <= 1'b0;
      pll_en_r <= 1'b0;
      low_power_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      pair_r <= pair_nxt;
      pll_ref_r <= pll_ref_nxt;
      pll_en_r <= pll_en_nxt;
      low_power_r <= low_power_nxt;
    end
  end

  assign serial_p_o = pair_r.p;
  assign serial_n_o = pair_r.n;
  assign serial_oe_o = pair_r.oe;
  assign pll_ref_o = pll_ref_r;
  assign pll_en_o = pll_en_r;
  assign low_power_o = low_power_r;

  // ============================================================
  // wishbone register slave
  logic ack_r; // acknowledge
  logic ack_nxt;
  logic [31:0] dat_r; // read data
  logic [31:0] dat_nxt;
  logic mute_nxt;
  logic req_take_s; // new request this cycle

  assign req_take_s = wb_cyc_i & wb_stb_i & ~ack_r;

  // decode, write and read
  always_comb begin
    ack_nxt = req_take_s;
    dat_nxt = '0;
    mute_nxt = mute_r;
    if (req_take_s) begin
      case (wb_adr_i)
        `SCF_OFS_CTRL: begin
          if (wb_we_i && wb_sel_i[0]) begin
            mute_nxt = wb_dat_i[`SCF_CTRL_MUTE_BIT];
          end
          dat_nxt[`SCF_CTRL_MUTE_BIT] = mute_r;
        end
        `SCF_OFS_STATUS: begin
          dat_nxt[`SCF_ST_INIT_BIT] = (state_r == scf_pkg::SCF_ST_INIT);
          dat_nxt[`SCF_ST_BURST_BIT] = (state_r == scf_pkg::SCF_ST_SYNC);
          dat_nxt[`SCF_ST_REQ_BIT] = req_s;
          dat_nxt[`SCF_ST_AWAKE_BIT] = power_down_n_i;
          dat_nxt[`SCF_ST_OE_BIT] = pair_r.oe;
        end
        `SCF_OFS_PATCNT: begin
          dat_nxt[CNT_W-1:0] = cnt_r;
        end
        `SCF_OFS_LATCH: begin
          dat_nxt[DATA_W-1:0] = latch_r;
        end
        default: begin
          // unmapped: acknowledged, reads zero, writes ignored
          dat_nxt = '0;
        end
      endcase
    end
  end

  // register the bus answer and control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
      mute_r <= `SCF_CTRL_RESET;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      mute_r <= mute_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule : scf_front_end
`default_nettype wire

// ---- scf_front_end_monitor.sv ----
// scf_front_end_monitor.sv: port assertions for the front end.
// assumes: bound into every scf_front_end; one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
module scf_front_end_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic transmit_clock_i,
  input wire logic serial_output_enable_i,
  input wire logic power_down_n_i,
  input wire logic serial_p_o,
  input wire logic serial_n_o,
  input wire logic serial_oe_o,
  input wire logic pll_ref_o,
  input wire logic pll_en_o,
  input wire logic low_power_o
);
  // ========
  // checks on clk_i, quiet while reset is high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  oe_den_off_a: assert property (!serial_output_enable_i |=> !serial_oe_o)
    else $error("pair driven with enable low");
  oe_pwr_off_a: assert property (!power_down_n_i |=> !serial_oe_o)
    else $error("pair driven in power-down");
  pll_stop_a: assert property (!power_down_n_i |=> !pll_en_o && low_power_o)
    else $error("pll still running in power-down");
  pll_run_a: assert property (power_down_n_i |=> pll_en_o && !low_power_o)
    else $error("pll not running while awake");
  pll_ref_a: assert property (power_down_n_i |=> pll_ref_o == $past(transmit_clock_i))
    else $error("pll reference does not follow the transmit clock");
  pair_comp_a: assert property (serial_oe_o |-> serial_n_o != serial_p_o)
    else $error("serial pair not complementary");
  oe_cause_a: assert property ($rose(serial_oe_o) |-> $past(serial_output_enable_i))
    else $error("pair enabled without output enable");
  ack_taken_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
endmodule : scf_front_end_monitor
bind scf_front_end scf_front_end_monitor scf_front_end_monitor_inst (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .transmit_clock_i, .serial_output_enable_i,
  .power_down_n_i, .serial_p_o, .serial_n_o, .serial_oe_o, .pll_ref_o, .pll_en_o,
  .low_power_o);
`default_nettype wire

// ---- scf_pkg.sv ----
// scf_pkg.sv: types shared by the serializer control front end.
// assumes: nothing; offsets and counts live in scf_regs.svh.
package scf_pkg;

  // ============================================================
  // operating states of the link sequencer
  typedef enum logic [1:0] {
    SCF_ST_INIT,
    SCF_ST_DATA,
    SCF_ST_SYNC
  } scf_state_t;

  // ============================================================
  // differential output pair with its drive enable
  typedef struct packed {
    logic p;
    logic n;
    logic oe;
  } scf_pair_t;

  // ============================================================
  // edges seen on the sampled transmit clock
  typedef struct packed {
    logic rise;
    logic fall;
    logic strobe;
  } scf_edges_t;

endpackage : scf_pkg

// ---- scf_regs.svh ----
// scf_regs.svh: register offsets, field positions, reset values and counts
// for the serializer control front end.
// assumes: included by bare name; holds definitions only.
`ifndef SCF_REGS_SVH
`define SCF_REGS_SVH

// ============================================================
// register byte offsets on the wishbone bus
`define SCF_OFS_CTRL 8'h00
`define SCF_OFS_STATUS 8'h04
`define SCF_OFS_PATCNT 8'h08
`define SCF_OFS_LATCH 8'h0c

// ============================================================
// field positions
`define SCF_CTRL_MUTE_BIT 0
`define SCF_ST_INIT_BIT 0
`define SCF_ST_BURST_BIT 1
`define SCF_ST_REQ_BIT 2
`define SCF_ST_AWAKE_BIT 3
`define SCF_ST_OE_BIT 4

// ============================================================
// reset values
`define SCF_CTRL_RESET 1'h0

// ============================================================
// timing counts, in transmit clock cycles
`define SCF_SYNC_HOLD 6
`define SCF_BURST_LEN 1026
`define SCF_INIT_LEN 1026

// fixed synchronisation word sent during a burst
`define SCF_SYNC_WORD 10'h3e0

`endif

// ---- test_serializer_control_front_end.sv ----
// test_serializer_control_front_end.sv: self-checking bench of the front end.
// assumes: short init and burst counts (8) set at the instance.
`timescale 1ns/100ps
`default_nettype none
`include "scf_regs.svh"
module test_serializer_control_front_end;
  typedef struct packed {logic sel; logic [9:0] a; logic [9:0] b; logic [9:0] e;} scf_row_t;
  logic clk_i, rst_i, cyc, stb, we, transmit_clock, esel, serial_output_enable, pwr_n, req_a, req_b, sync_seen;
  logic ack, sp, sn, soe, pref, pen, lowp, line_err;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, dat_o;
  logic [9:0] pdat, rx_word;
  int fails, total_checks;
  // latch rows: edge select, word before fall, word before rise, expected
  scf_row_t rows [4] = '{'{1'b0, 10'h155, 10'h2aa, 10'h155}, '{1'b1, 10'h155, 10'h2aa, 10'h2aa},
    '{1'b0, 10'h3ff, 10'h000, 10'h3ff}, '{1'b1, 10'h3ff, 10'h000, 10'h000}};
  scf_front_end #(.INIT_LEN(8), .BURST_LEN(8)) scf_front_end_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .transmit_clock_i(transmit_clock), .transmit_strobe_edge_select_i(esel),
    .parallel_data_in_i(pdat), .serial_output_enable_i(serial_output_enable), .power_down_n_i(pwr_n),
    .sync_request_a_i(req_a), .sync_request_b_i(req_b), .serial_p_o(sp), .serial_n_o(sn),
    .serial_oe_o(soe), .pll_ref_o(pref), .pll_en_o(pen), .low_power_o(lowp));
  scf_deser_model scf_deser_model_inst (.clk_i(clk_i), .serial_p_i(sp), .serial_n_i(sn),
    .serial_oe_i(soe), .rx_word_o(rx_word), .line_err_o(line_err));
  // ========
  // clocks: 40 MHz system, transmit clock of 16 system cycles
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always begin
    repeat (8) @(posedge clk_i);
    transmit_clock <= ~transmit_clock;
  end
  // remember any received sync word
  always @(posedge clk_i) begin
    if (rx_word === `SCF_SYNC_WORD) begin
      sync_seen <= 1'b1;
    end
  end
  // ========
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
    end
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask : rd
  task automatic rises(input int n);
    repeat (n) @(posedge transmit_clock);
    repeat (3) @(posedge clk_i);
  endtask : rises
  task automatic test_done();
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    test_done();
  end
  // ========
  // main sequence
  initial begin
    {cyc, stb, we, transmit_clock, req_a, req_b, sync_seen, esel, serial_output_enable, pwr_n, rst_i} = 11'h00f;
    {adr, wdat, pdat, fails, total_checks} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SCF_OFS_CTRL, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(`SCF_OFS_STATUS, 32'h0000_0009);
    rises(9);
    rd(`SCF_OFS_STATUS, 32'h0000_0018);
    foreach (rows[i]) begin
      esel <= rows[i].sel;
      @(posedge transmit_clock);
      repeat (3) @(posedge clk_i);
      pdat <= rows[i].a;
      @(negedge transmit_clock);
      repeat (3) @(posedge clk_i);
      pdat <= rows[i].b;
      rises(1);
      rd(`SCF_OFS_LATCH, {22'h00_0000, rows[i].e});
    end
    serial_output_enable <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(soe, 32'h0000_0000);
    serial_output_enable <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(soe, 32'h0000_0001);
    wb(1'b1, `SCF_OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk(soe, 32'h0000_0000);
    wb(1'b1, `SCF_OFS_CTRL, 32'h0000_0000);
    sync_seen <= 1'b0;
    req_a <= 1'b1;
    repeat (5) @(posedge transmit_clock);
    req_a <= 1'b0;
    rises(1);
    rd(`SCF_OFS_STATUS, 32'h0000_0018);
    req_b <= 1'b1;
    rises(7);
    req_b <= 1'b0;
    rd(`SCF_OFS_STATUS, 32'h0000_001a);
    rises(3);
    rd(`SCF_OFS_STATUS, 32'h0000_001a);
    rises(8);
    rd(`SCF_OFS_STATUS, 32'h0000_0018);
    chk(sync_seen, 32'h0000_0001);
    req_a <= 1'b1;
    rises(20);
    rd(`SCF_OFS_STATUS, 32'h0000_001e);
    req_a <= 1'b0;
    rises(2);
    rd(`SCF_OFS_STATUS, 32'h0000_0018);
    req_b <= 1'b1;
    rises(7);
    req_b <= 1'b0;
    rd(`SCF_OFS_STATUS, 32'h0000_001a);
    pwr_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({pen, lowp, soe, pref}, 32'h0000_0004);
    pwr_n <= 1'b1;
    rises(2);
    rd(`SCF_OFS_STATUS, 32'h0000_0009);
    rises(7);
    rd(`SCF_OFS_STATUS, 32'h0000_0018);
    chk(line_err, 32'h0000_0000);
    test_done();
  end
endmodule : test_serializer_control_front_end
`default_nettype wire
